/* File: core/adc_sequencer.sv */
// Purpose: Sequencer for a dual simultaneous sampling converter.
// Assumes: Converter clock is clk; analog codes arrive as inputs.
// Notes: Registers on a plain strobe port, read data one cycle later.
//
// How it works
// - Bandgap on at reset with no settle wait; settles 2us after a power-down.
// - Converter off; start needs bandgap, RC, PLL.
// - Default clock 40 MHz gives 2.5 Msps.
// - Each conversion 3 sample plus 13 cycles.
// - Two inputs sampled together, stored separately.
// - Single or scan, one-shot or continuous.
// - Twenty per-channel result registers.
// - Software or counted timer trigger starts.
// - Channel 18 offset subtracted from others.
// - Offset loaded from calibration at reset.
// - Reference select and per-sampler gain select.
// - Two-bit bias trim field.
// - Two-bit converter clock select field.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_params.svh"
module adc_sequencer
   import adc_seq_pkg::*;
#(
   parameter int NCH = `NUM_CHAN,
   parameter int BG_CYC = `BG_SETTLE_CYC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire adc_seq_pkg::reg_req_t req,
   output logic [31:0] rdata,
   input wire logic [3:0] pwm_trig,
   input wire logic [11:0] cal_offset,
   input wire logic [11:0] code_a,
   input wire logic [11:0] code_b,
   output logic [4:0] chan_sel,
   output logic sample_hold,
   output logic [1:0] sampler_gain_select,
   output logic ref_select,
   output logic [1:0] converter_bias_trim,
   output logic [1:0] converter_clock_select,
   output logic bandgap_power_down,
   output logic pll_enable,
   output logic temp_sensor_enable,
   output logic converter_on
);
   import adc_seq_pkg::*;
   initial begin
      if (NCH != 20) $error("channel count must be 20");
      if (BG_CYC < 1) $error("settle count must be positive");
   end
   // ****************************************
   // Register state.
   // ****************************************
   logic [31:0] ctrl_q, ctrl_d, an_q, an_d, trig_q, trig_d;
   logic [4:0] list_q [NCH];
   logic [4:0] list_d [NCH];
   logic [11:0] offs_q, offs_d;
   logic offs_loaded_q;
   logic [11:0] res_q [NCH];
   logic [11:0] res_d [NCH];
   logic done_q, done_d, sw_go;
   logic [31:0] rdata_q, rdata_d;
   logic [3:0] ts1_q, ts2_q;
   logic tfire;
   logic [15:0] bg_cnt_q, bg_cnt_d;
   logic bg_ok;
   // ****************************************
   // Sequencer state.
   // ****************************************
   seq_state_t st_q, st_d;
   logic [4:0] cyc_q, cyc_d, idx_q, idx_d;
   logic [11:0] a_q, a_d, b_q, b_d;
   logic start, ready, last;
   logic [4:0] cur_ch, cur_chb, nxt_ch;
   function automatic logic [11:0] corr(input logic [11:0] v,
                                        input logic [11:0] o,
                                        input logic [4:0] ch);
      corr = (ch == `OFFSET_CHAN) ? v : v - o;
   endfunction
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ts1_q <= 4'h0;
         ts2_q <= 4'h0;
      end else begin
         ts1_q <= pwm_trig;
         ts2_q <= ts1_q;
      end
   end
   // Timer trigger events are counted after the two-stage synchroniser.
   trig_counter #(.NTRIG(4)) u_trig (
      .clk(clk),
      .reset_n(reset_n),
      .trig(ts2_q),
      .trig_en(trig_q[3:0]),
      .preset(trig_q[7:4]),
      .fire(tfire)
   );
   // Bandgap settle counter restarts on every off to on change.
   always_comb begin
      bg_cnt_d = bg_cnt_q;
      if (an_q[`AN_BGPD_BIT]) begin
         bg_cnt_d = 16'(BG_CYC);
      end else if (bg_cnt_q != 16'h0) begin
         bg_cnt_d = bg_cnt_q - 16'h1;
      end
   end
   assign bg_ok = (bg_cnt_q == 16'h0);
   assign ready = ctrl_q[`CTRL_EN_BIT] && bg_ok && an_q[`AN_PLL_BIT]
                  && an_q[`AN_RC_BIT];
   assign sw_go = req.wr && req.addr == `REG_CTRL
                  && req.wdata[`CTRL_SW_BIT];
   assign start = ready && (sw_go || tfire);
   assign cur_ch = ctrl_q[`CTRL_SCAN_BIT] ? list_q[idx_q]
                   : ctrl_q[`CTRL_CHAN_LSB +: 5];
   assign cur_chb = (cur_ch == 5'(NCH - 1)) ? 5'h0 : cur_ch + 5'h1;
   assign last = !ctrl_q[`CTRL_SCAN_BIT]
                 || idx_q >= ctrl_q[`CTRL_LEN_LSB +: 5];
   // The channel is steered from the next state so that it already
   // stands on the new entry in the first sample cycle.
   assign nxt_ch = ctrl_d[`CTRL_SCAN_BIT] ? list_d[idx_d]
                   : ctrl_d[`CTRL_CHAN_LSB +: 5];
   // ****************************************
   // Conversion sequence.
   // ****************************************
   always_comb begin
      st_d = st_q;
      cyc_d = cyc_q;
      idx_d = idx_q;
      a_d = a_q;
      b_d = b_q;
      for (int i = 0; i < NCH; i++) begin
         res_d[i] = res_q[i];
      end
      done_d = done_q;
      if (req.rd && req.addr == `REG_STATUS) begin
         done_d = 1'b0;
      end
      unique case (st_q)
         ST_IDLE: begin
            if (start) begin
               st_d = ST_SAMPLE;
               cyc_d = 5'h0;
               idx_d = 5'h0;
            end
         end
         ST_SAMPLE: begin
            cyc_d = cyc_q + 5'h1;
            if (cyc_q == `SAMPLE_CYC - 5'h1) begin
               a_d = code_a;
               b_d = code_b;
               st_d = ST_CONV;
               cyc_d = 5'h0;
            end
         end
         ST_CONV: begin
            cyc_d = cyc_q + 5'h1;
            if (cyc_q == `CONV_CYC - 5'h1) begin
               res_d[cur_ch] = corr(a_q, offs_q, cur_ch);
               res_d[cur_chb] = corr(b_q, offs_q, cur_chb);
               cyc_d = 5'h0;
               if (!ready) begin
                  st_d = ST_IDLE;
               end else if (!last) begin
                  idx_d = idx_q + 5'h1;
                  st_d = ST_SAMPLE;
               end else begin
                  done_d = 1'b1;
                  idx_d = 5'h0;
                  st_d = ctrl_q[`CTRL_CONT_BIT] ? ST_SAMPLE : ST_IDLE;
               end
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end
   // ****************************************
   // Register writes and reads.
   // ****************************************
   always_comb begin
      ctrl_d = ctrl_q;
      an_d = an_q;
      trig_d = trig_q;
      offs_d = offs_q;
      for (int i = 0; i < NCH; i++) begin
         list_d[i] = list_q[i];
      end
      if (req.wr) begin
         unique case (req.addr)
            `REG_CTRL: ctrl_d = req.wdata & 32'h001F_1F0D;
            `REG_ANALOG: an_d = req.wdata & 32'h0000_0FFF;
            `REG_TRIG: trig_d = req.wdata & 32'h0000_00FF;
            `REG_OFFSET: offs_d = req.wdata[11:0];
            `REG_LIST0, `REG_LIST1, `REG_LIST2, `REG_LIST3: begin
               for (int k = 0; k < 5; k++) begin
                  list_d[5'((req.addr - `REG_LIST0) * 5 + k)] =
                     req.wdata[k*6 +: 5];
               end
            end
            default: ;
         endcase
      end
      // The calibrated offset is taken once, on the first cycle after reset.
      if (!offs_loaded_q) begin
         offs_d = cal_offset;
      end
      rdata_d = 32'h0;
      if (req.rd) begin
         if (req.addr >= `REG_RESULT0
             && req.addr < `REG_RESULT0 + 6'(NCH)) begin
            rdata_d = {20'h0, res_q[5'(req.addr - `REG_RESULT0)]};
         end else begin
            unique case (req.addr)
               `REG_CTRL: rdata_d = ctrl_q;
               `REG_ANALOG: rdata_d = an_q;
               `REG_TRIG: rdata_d = trig_q;
               `REG_OFFSET: rdata_d = {20'h0, offs_q};
               `REG_STATUS: rdata_d = {29'h0, bg_ok, st_q != ST_IDLE,
                                       done_q};
               `REG_LIST0, `REG_LIST1, `REG_LIST2, `REG_LIST3: begin
                  for (int k = 0; k < 5; k++) begin
                     rdata_d[k*6 +: 5] =
                        list_q[5'((req.addr - `REG_LIST0) * 5 + k)];
                  end
               end
               default: rdata_d = 32'h0;
            endcase
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctrl_q <= 32'h0;
         an_q <= `AN_RESET;
         trig_q <= 32'h0;
         offs_q <= 12'h000;
         offs_loaded_q <= 1'b0;
         rdata_q <= 32'h0;
         bg_cnt_q <= 16'h0;
         st_q <= ST_IDLE;
         cyc_q <= 5'h0;
         idx_q <= 5'h0;
         a_q <= 12'h000;
         b_q <= 12'h000;
         done_q <= 1'b0;
         for (int i = 0; i < NCH; i++) begin
            list_q[i] <= 5'(i);
            res_q[i] <= 12'h000;
         end
      end else begin
         ctrl_q <= ctrl_d;
         an_q <= an_d;
         trig_q <= trig_d;
         offs_loaded_q <= 1'b1;
         offs_q <= offs_d;
         rdata_q <= rdata_d;
         bg_cnt_q <= bg_cnt_d;
         st_q <= st_d;
         cyc_q <= cyc_d;
         idx_q <= idx_d;
         a_q <= a_d;
         b_q <= b_d;
         done_q <= done_d;
         for (int i = 0; i < NCH; i++) begin
            list_q[i] <= list_d[i];
            res_q[i] <= res_d[i];
         end
      end
   end
   // ****************************************
   // Registered outputs.
   // ****************************************
   logic [4:0] chan_q;
   logic sh_q, sh_d;
   assign sh_d = (st_d == ST_SAMPLE);
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         chan_q <= 5'h0;
         sh_q <= 1'b0;
      end else begin
         chan_q <= nxt_ch;
         sh_q <= sh_d;
      end
   end
   assign rdata = rdata_q;
   assign chan_sel = chan_q;
   assign sample_hold = sh_q;
   assign bandgap_power_down = an_q[`AN_BGPD_BIT];
   assign pll_enable = an_q[`AN_PLL_BIT];
   assign temp_sensor_enable = an_q[`AN_TEMP_BIT];
   assign ref_select = an_q[`AN_REFSEL_BIT];
   assign sampler_gain_select = an_q[`AN_GAIN_LSB +: 2];
   assign converter_bias_trim = an_q[`AN_BIAS_LSB +: 2];
   assign converter_clock_select = an_q[`AN_CLKSEL_LSB +: 2];
   assign converter_on = ctrl_q[`CTRL_EN_BIT];
endmodule
`default_nettype wire

/* File: core/adc_seq_params.svh */
// Purpose: Constants for the dual sampling converter sequencer.
// Assumes: Included by bare name from design files.
// Notes: Offsets are word indices on the plain register port.
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH
`define ADDR_W 6
`define REG_CTRL 6'h00
`define REG_ANALOG 6'h01
`define REG_TRIG 6'h02
`define REG_LIST0 6'h03
`define REG_LIST1 6'h04
`define REG_LIST2 6'h05
`define REG_LIST3 6'h06
`define REG_OFFSET 6'h07
`define REG_STATUS 6'h08
`define REG_RESULT0 6'h10
`define CTRL_EN_BIT 0
`define CTRL_SW_BIT 1
`define CTRL_SCAN_BIT 2
`define CTRL_CONT_BIT 3
`define CTRL_LEN_LSB 8
`define CTRL_CHAN_LSB 16
`define AN_BGPD_BIT 0
`define AN_PLL_BIT 1
`define AN_TEMP_BIT 2
`define AN_RC_BIT 3
`define AN_REFSEL_BIT 4
`define AN_GAIN_LSB 5
`define AN_BIAS_LSB 8
`define AN_CLKSEL_LSB 10
`define AN_RESET 32'h0000_0008
`define STAT_DONE_BIT 0
`define STAT_BUSY_BIT 1
`define STAT_BG_BIT 2
`define SAMPLE_CYC 5'h03
`define CONV_CYC 5'h0D
`define BG_SETTLE_NS 2000
`define CLK_NS 25
`define BG_SETTLE_CYC ((`BG_SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`define OFFSET_CHAN 5'h12
`define NUM_CHAN 20
`endif

/* File: core/adc_seq_pkg.sv */
// Purpose: Types for the dual sampling converter sequencer.
// Assumes: Nothing.
// Notes: Constants live in the params header.
package adc_seq_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_CONV = 2'b10
   } seq_state_t;
   typedef struct packed {
      logic [5:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;
   typedef struct packed {
      logic [1:0] fire;
      logic [11:0] code_a;
      logic [11:0] code_b;
   } conv_out_t;
endpackage

/* File: core/trig_counter.sv */
// Purpose: Counts external trigger events and fires at a preset count.
// Assumes: Trigger inputs already synchronised.
// Notes: One counter per trigger line.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_params.svh"
module trig_counter #(
   parameter int NTRIG = 4
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [NTRIG-1:0] trig,
   input wire logic [NTRIG-1:0] trig_en,
   input wire logic [3:0] preset,
   output logic fire
);
   logic [NTRIG-1:0] prev_q, prev_d, hit;
   logic [3:0] cnt_q [NTRIG];
   logic [3:0] cnt_d [NTRIG];
   initial begin
      if (NTRIG < 1) $error("trigger count must be positive");
   end
   // ****************************************
   // Per line event counting.
   // ****************************************
   for (genvar i = 0; i < NTRIG; i++) begin : g_line
      always_comb begin
         cnt_d[i] = cnt_q[i];
         hit[i] = 1'b0;
         if (trig_en[i] && trig[i] && !prev_q[i]) begin
            if (cnt_q[i] >= preset) begin
               cnt_d[i] = 4'h0;
               hit[i] = 1'b1;
            end else begin
               cnt_d[i] = cnt_q[i] + 4'h1;
            end
         end
      end
      always_ff @(posedge clk) begin
         if (!reset_n) begin
            cnt_q[i] <= 4'h0;
         end else begin
            cnt_q[i] <= cnt_d[i];
         end
      end
   end
   assign prev_d = trig;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         prev_q <= '0;
      end else begin
         prev_q <= prev_d;
      end
   end
   assign fire = |hit;
endmodule
`default_nettype wire

/* File: tb/adc_seq_checker.sv */
// Purpose: Temporal checks on the sequencer ports.
// Assumes: Bound to every sequencer instance.
// Notes: One clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_params.svh"
module adc_seq_checker (
   input wire logic clk,
   input wire logic reset_n,
   input wire adc_seq_pkg::reg_req_t req,
   input wire logic [4:0] chan_sel,
   input wire logic sample_hold,
   input wire logic [1:0] sampler_gain_select,
   input wire logic ref_select,
   input wire logic [1:0] converter_bias_trim,
   input wire logic [1:0] converter_clock_select,
   input wire logic bandgap_power_down,
   input wire logic pll_enable,
   input wire logic temp_sensor_enable,
   input wire logic converter_on
);
   import adc_seq_pkg::*;
   // ***
   // Checks.
   // ***
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic sh_q;
   logic [4:0] gap_q;
   // The gap counter holds cycles since the last sample start.
   always_ff @(posedge clk) begin
      sh_q <= reset_n && sample_hold;
      if (!reset_n || (sample_hold && !sh_q)) begin
         gap_q <= {4'h0, reset_n};
      end else if (gap_q != 5'h00 && gap_q != 5'h1F) begin
         gap_q <= gap_q + 5'h01;
      end
   end
   sequence s_hold3;
      sample_hold [*3] ##1 !sample_hold;
   endsequence
   a_sample_three: assert property ($rose(sample_hold) |-> s_hold3)
      else $error("sample phase not three cycles");
   a_conv_gap: assert property (sample_hold && !sh_q
      |-> gap_q == 5'h00 || gap_q >= 5'h10)
      else $error("conversions closer than sixteen cycles");
   a_chan_steady: assert property (sample_hold && $past(sample_hold)
      |-> $stable(chan_sel))
      else $error("channel moved while sampling");
   a_hold_needs_on: assert property (sample_hold |-> converter_on)
      else $error("sampling while converter off");
   a_hold_needs_ref: assert property (sample_hold
      |-> pll_enable && !bandgap_power_down)
      else $error("sampling without pll or bandgap");
   a_analog_fields: assert property ($past(req.wr)
      && $past(req.addr) == `REG_ANALOG
      |-> {converter_clock_select, converter_bias_trim, sampler_gain_select,
      ref_select} == {$past(req.wdata[11:8]), $past(req.wdata[6:4])})
      else $error("analog fields do not follow write");
   a_power_fields: assert property ($past(req.wr)
      && $past(req.addr) == `REG_ANALOG
      |-> {temp_sensor_enable, pll_enable, bandgap_power_down}
      == $past(req.wdata[2:0]))
      else $error("power controls do not follow write");
   a_reset_state: assert property ($rose(reset_n)
      |-> !converter_on && !bandgap_power_down && !pll_enable)
      else $error("wrong state after reset");
endmodule
bind adc_sequencer adc_seq_checker u_chk (
   .clk(clk), .reset_n(reset_n), .req(req), .chan_sel(chan_sel),
   .sample_hold(sample_hold), .sampler_gain_select(sampler_gain_select),
   .ref_select(ref_select), .converter_bias_trim(converter_bias_trim),
   .converter_clock_select(converter_clock_select),
   .bandgap_power_down(bandgap_power_down), .pll_enable(pll_enable),
   .temp_sensor_enable(temp_sensor_enable), .converter_on(converter_on)
);
`default_nettype wire

/* File: tb/analog_source.sv */
// Purpose: Analog channel model feeding the sampler codes.
// Assumes: Codes are taken while sample_hold is high.
// Notes: Between samples the codes toggle so stale values show.
`timescale 1ns/1ps
`default_nettype none
module analog_source (
   input wire logic clk,
   input wire logic sample_hold,
   input wire logic [4:0] chan_sel,
   output logic [11:0] code_a,
   output logic [11:0] code_b
);
   // ***
   // Channel levels.
   // ***
   logic [4:0] chan_b;
   logic [11:0] a_q = 12'h000;
   logic [11:0] b_q = 12'h000;
   function automatic logic [11:0] level(input logic [4:0] c);
      return (c == 5'h12) ? 12'h010 : {c, 7'h15};
   endfunction
   assign chan_b = (chan_sel == 5'h13) ? 5'h00 : chan_sel + 5'h01;
   always_ff @(posedge clk) begin
      if (sample_hold) begin
         a_q <= level(chan_sel);
         b_q <= level(chan_b);
      end else begin
         a_q <= ~a_q;
         b_q <= ~b_q;
      end
   end
   assign code_a = a_q;
   assign code_b = b_q;
endmodule
`default_nettype wire

/* File: tb/adc_sequencer_tb.sv */
// Purpose: Self-checking bench for the converter sequencer.
// Assumes: Analog model drives the code inputs.
// Notes: Bandgap settle count shortened to BGC cycles.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_params.svh"
module adc_sequencer_tb;
   import adc_seq_pkg::*;
   // ***
   // Bench.
   // ***
   localparam int BGC = 20;
   localparam logic [11:0] CAL = 12'h00A;
   logic clk;
   logic reset_n;
   reg_req_t req;
   logic [31:0] rdata;
   logic [3:0] pwm_trig;
   logic [11:0] code_a;
   logic [11:0] code_b;
   logic [4:0] chan_sel;
   logic sample_hold, ref_sel, bg_pd, pll_en, temp_en, conv_on;
   logic [1:0] gain, bias, clk_sel;
   int error_cnt = 0;
   int compares = 0;
   bit found;
   logic [4:0] ch;
   adc_sequencer #(.BG_CYC(BGC)) u_dut (
      .clk(clk), .reset_n(reset_n), .req(req), .rdata(rdata),
      .pwm_trig(pwm_trig), .cal_offset(CAL), .code_a(code_a),
      .code_b(code_b), .chan_sel(chan_sel), .sample_hold(sample_hold),
      .sampler_gain_select(gain), .ref_select(ref_sel),
      .converter_bias_trim(bias), .converter_clock_select(clk_sel),
      .bandgap_power_down(bg_pd), .pll_enable(pll_en),
      .temp_sensor_enable(temp_en), .converter_on(conv_on)
   );
   analog_source u_src (
      .clk(clk), .sample_hold(sample_hold), .chan_sel(chan_sel),
      .code_a(code_a), .code_b(code_b)
   );
   function automatic logic [31:0] res(input logic [4:0] c);
      return {20'h0, (c == 5'h12) ? 12'h010 : {c, 7'h15} - 12'h010};
   endfunction
   task automatic chk(input bit ok, input string msg);
      compares++;
      if (!ok) begin
         error_cnt++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] e, string m);
      @(posedge clk);
      req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '0;
      #1;
      chk(rdata === e, m);
   endtask
   task automatic hold(input int mx);
      found = 0;
      for (int i = 0; i < mx && !found; i++) begin
         @(posedge clk);
         #1;
         found = (sample_hold === 1'b1);
         ch = chan_sel;
      end
      repeat (3) @(posedge clk);
   endtask
   task automatic t_reset;
      chk(bg_pd === 1'b0 && conv_on === 1'b0, "reset outputs");
      rd(`REG_ANALOG, `AN_RESET, "analog reset");
      rd(`REG_OFFSET, {20'h0, CAL}, "cal offset");
      rd(6'h3F, 32'h0, "unmapped read");
      wr(`REG_CTRL, 32'h0011_0003);
      hold(30);
      chk(!found, "start without pll");
      wr(`REG_ANALOG, 32'h0000_0E2E);
      #1;
      chk({clk_sel, bias, gain, ref_sel} === 7'h72, "fields");
      chk({temp_en, pll_en, bg_pd} === 3'b110, "power");
      repeat (240) @(posedge clk);
      $display("test reset done");
   endtask
   task automatic t_single;
      wr(`REG_OFFSET, 32'h0000_0010);
      wr(`REG_CTRL, 32'h0011_0003);
      hold(10);
      chk(found && ch === 5'h11 && conv_on === 1'b1, "single");
      repeat (13) @(posedge clk);
      rd(`REG_STATUS, 32'h5, "done set");
      rd(`REG_STATUS, 32'h4, "done clear");
      rd(`REG_RESULT0 + 6'h11, res(5'h11), "offset cut");
      rd(`REG_RESULT0 + 6'h12, res(5'h12), "ground chan");
      wr(`REG_CTRL, 32'h0011_000B);
      hold(10);
      rd(`REG_STATUS, 32'h6, "busy");
      hold(20);
      chk(found && ch === 5'h11, "cont single");
      wr(`REG_CTRL, 32'h0011_0001);
      hold(20);
      chk(!found, "cont single stop");
      $display("test single done");
   endtask
   task automatic t_scan;
      logic [4:0] e [4] = '{5'h02, 5'h04, 5'h06, 5'h02};
      wr(`REG_LIST0, 32'h0000_6102);
      wr(`REG_CTRL, 32'h0000_020F);
      for (int i = 0; i < 4; i++) begin
         hold(20);
         chk(found && ch === e[i], "cont scan");
      end
      wr(`REG_CTRL, 32'h0);
      hold(20);
      chk(!found, "stop");
      wr(`REG_CTRL, 32'h0000_0205);
      wr(`REG_CTRL, 32'h0000_0207);
      for (int i = 0; i < 4; i++) begin
         hold(20);
         chk(found == (i < 3) && (i == 3 || ch === e[i]), "scan");
      end
      $display("test scan done");
   endtask
   task automatic t_trig;
      wr(`REG_TRIG, 32'h0000_0021);
      wr(`REG_CTRL, 32'h0003_0001);
      for (int i = 0; i < 3; i++) begin
         pwm_trig <= 4'h1;
         repeat (3) @(posedge clk);
         pwm_trig <= 4'h0;
         hold(12);
         chk(found == (i == 2) && (i < 2 || ch === 5'h03), "trig");
      end
      repeat (16) @(posedge clk);
      $display("test trigger done");
   endtask
   task automatic t_bg;
      wr(`REG_CTRL, 32'h0);
      wr(`REG_ANALOG, 32'h0000_0E2F);
      wr(`REG_ANALOG, 32'h0000_0E2E);
      wr(`REG_CTRL, 32'h0011_0001);
      wr(`REG_CTRL, 32'h0011_0003);
      hold(8);
      chk(!found, "unsettled start");
      repeat (BGC) @(posedge clk);
      wr(`REG_CTRL, 32'h0011_0003);
      hold(8);
      chk(found, "settled start");
      $display("test bandgap done");
   endtask
   task automatic summarize;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      chk(1'b0, "watchdog");
      summarize;
   end
   initial begin
      reset_n <= 1'b0;
      req <= '0;
      pwm_trig <= 4'h0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      #1;
      t_reset;
      t_single;
      t_scan;
      t_trig;
      t_bg;
      summarize;
   end
endmodule
`default_nettype wire
